// ### src/cdt_timer.sv
// Countdown timer with auto-reload, APB register slave and interrupt flag
module cdt_timer #(
  parameter int BASE_CYCLES = cdt_pkg::CDT_BASE_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cdt_pkg::CDT_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic INT_N_O,
  output logic INT_OE_N
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cdt_pkg::cdt_ctrl_s ctrl_reg;
  cdt_pkg::cdt_state_e state_reg;
  logic irq_en_reg;
  logic flag_reg;
  logic [15:0] load_reg;
  logic [15:0] cnt_reg;
  logic [31:0] pre_reg;
  logic [5:0] div_reg;
  logic [31:0] prdata_reg;
  logic base_tick;
  logic src_tick;
  logic wr_acc;
  logic rd_setup;
  logic [7:0] idx;
  logic mapped;
  logic wr_ctrl;
  logic wr_ien;
  logic wr_iflg;
  logic wr_lo;
  logic wr_hi;
  logic run_start;
  logic done_pulse;
  logic flag_clear;

  // Source tick decode: picks which base ticks count for the selected rate
  function automatic logic src_pick(input cdt_pkg::cdt_src_e sel, input logic [5:0] div);
    logic hit;
    hit = 1'b0;
    case (sel)
      cdt_pkg::CDT_SRC_32HZ: hit = 1'b1;
      cdt_pkg::CDT_SRC_8HZ: hit = (div[1:0] == cdt_pkg::CDT_DIV_8HZ[1:0]);
      cdt_pkg::CDT_SRC_1HZ: hit = (div[4:0] == cdt_pkg::CDT_DIV_1HZ[4:0]);
      cdt_pkg::CDT_SRC_HALF: hit = (div == cdt_pkg::CDT_DIV_HALF);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : src_pick

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Byte address is four times the register index; low two bits ignored
  assign idx = PADDR[cdt_pkg::CDT_ADDR_W-1:2];
  assign mapped = (idx == cdt_pkg::CDT_IDX_CTRL) || (idx == cdt_pkg::CDT_IDX_IEN) ||
                  (idx == cdt_pkg::CDT_IDX_IFLG) || (idx == cdt_pkg::CDT_IDX_CNTLO) ||
                  (idx == cdt_pkg::CDT_IDX_CNTHI);
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign wr_ctrl = wr_acc && (idx == cdt_pkg::CDT_IDX_CTRL);
  assign wr_ien = wr_acc && (idx == cdt_pkg::CDT_IDX_IEN);
  assign wr_iflg = wr_acc && (idx == cdt_pkg::CDT_IDX_IFLG);
  assign wr_lo = wr_acc && (idx == cdt_pkg::CDT_IDX_CNTLO);
  assign wr_hi = wr_acc && (idx == cdt_pkg::CDT_IDX_CNTHI);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = prdata_reg;

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_reg <= 32'h0000_0000;
      case (idx)
        cdt_pkg::CDT_IDX_CTRL: begin
          prdata_reg[cdt_pkg::CDT_CTRL_SEL_HI:cdt_pkg::CDT_CTRL_SEL_LO] <= ctrl_reg.sel;
          prdata_reg[cdt_pkg::CDT_CTRL_ARL] <= ctrl_reg.arl;
          prdata_reg[cdt_pkg::CDT_CTRL_RUN] <= ctrl_reg.run;
        end
        cdt_pkg::CDT_IDX_IEN: prdata_reg[cdt_pkg::CDT_IRQ_BIT] <= irq_en_reg;
        cdt_pkg::CDT_IDX_IFLG: prdata_reg[cdt_pkg::CDT_IRQ_BIT] <= flag_reg;
        cdt_pkg::CDT_IDX_CNTLO: prdata_reg[7:0] <= load_reg[7:0];
        cdt_pkg::CDT_IDX_CNTHI: prdata_reg[7:0] <= load_reg[15:8];
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Run bit always writable; select and reload only while stopped
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg.run <= 1'b0; // RULE13
      ctrl_reg.arl <= 1'b0; // RULE13
      ctrl_reg.sel <= cdt_pkg::cdt_src_e'(cdt_pkg::CDT_SEL_RESET); // RULE13
    end else if (wr_ctrl) begin
      ctrl_reg.run <= PWDATA[cdt_pkg::CDT_CTRL_RUN]; // RULE1
      if (!ctrl_reg.run) begin // RULE11
        ctrl_reg.arl <= PWDATA[cdt_pkg::CDT_CTRL_ARL]; // RULE6
        ctrl_reg.sel <= cdt_pkg::cdt_src_e'(PWDATA[cdt_pkg::CDT_CTRL_SEL_HI:cdt_pkg::CDT_CTRL_SEL_LO]); // RULE2
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_en_reg <= 1'b0;
    end else if (wr_ien) begin
      irq_en_reg <= PWDATA[cdt_pkg::CDT_IRQ_BIT];
    end
  end

  // Count value bytes, locked while running or in reload mode
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      load_reg <= cdt_pkg::CDT_CNT_RESET;
    end else if (!ctrl_reg.run && !ctrl_reg.arl) begin // RULE12
      if (wr_lo) begin
        load_reg[7:0] <= PWDATA[7:0]; // RULE3
      end
      if (wr_hi) begin
        load_reg[15:8] <= PWDATA[7:0]; // RULE3
      end
    end
  end

  // ----------------------------------------
  // Source clock generation
  // ----------------------------------------
  assign base_tick = (pre_reg == 32'(BASE_CYCLES - 1));
  assign src_tick = base_tick && src_pick(ctrl_reg.sel, div_reg); // RULE2

  // Free-running prescaler to the 32 Hz base and a divider for slower rates
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_reg <= 32'h0000_0000;
      div_reg <= 6'h00;
    end else if (base_tick) begin
      pre_reg <= 32'h0000_0000;
      div_reg <= div_reg + 6'h01;
    end else begin
      pre_reg <= pre_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Countdown state machine
  // ----------------------------------------
  assign run_start = wr_ctrl && !ctrl_reg.run && PWDATA[cdt_pkg::CDT_CTRL_RUN];
  assign done_pulse = (state_reg == cdt_pkg::CDT_ST_RUN) && src_tick && (cnt_reg == 16'h0001); // RULE5

  // Load on start, count on ticks, reload one tick after zero in auto mode
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= cdt_pkg::CDT_ST_IDLE;
      cnt_reg <= cdt_pkg::CDT_CNT_RESET;
    end else if (wr_ctrl && !PWDATA[cdt_pkg::CDT_CTRL_RUN]) begin
      state_reg <= cdt_pkg::CDT_ST_IDLE; // RULE1
    end else if (run_start) begin
      cnt_reg <= load_reg;
      if (load_reg == 16'h0000) begin
        state_reg <= cdt_pkg::CDT_ST_IDLE; // RULE4
      end else begin
        state_reg <= cdt_pkg::CDT_ST_RUN;
      end
    end else begin
      case (state_reg)
        cdt_pkg::CDT_ST_IDLE: state_reg <= cdt_pkg::CDT_ST_IDLE;
        cdt_pkg::CDT_ST_RUN: begin
          if (src_tick) begin
            cnt_reg <= cnt_reg - 16'h0001; // RULE17
            if (cnt_reg == 16'h0001) begin
              if (ctrl_reg.arl) begin
                state_reg <= cdt_pkg::CDT_ST_RELOAD; // RULE6
              end else begin
                state_reg <= cdt_pkg::CDT_ST_IDLE; // RULE16
              end
            end
          end
        end
        cdt_pkg::CDT_ST_RELOAD: begin
          if (src_tick) begin
            cnt_reg <= load_reg; // RULE7 RULE8
            state_reg <= cdt_pkg::CDT_ST_RUN;
          end
        end
        default: state_reg <= cdt_pkg::CDT_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Timer flag and interrupt pin
  // ----------------------------------------
  assign flag_clear = wr_iflg && !PWDATA[cdt_pkg::CDT_IRQ_BIT];

  // Sticky flag: an end of count in the clearing cycle wins
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_reg <= 1'b0;
    end else if (done_pulse && irq_en_reg) begin
      flag_reg <= 1'b1; // RULE9
    end else if (flag_clear) begin
      flag_reg <= 1'b0; // RULE10 RULE14
    end
  end

  // Open-drain pin: drives low while the flag is set
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      INT_OE_N <= 1'b1;
    end else begin
      INT_OE_N <= !((done_pulse && irq_en_reg) || (flag_reg && !flag_clear)); // RULE10 RULE15
    end
  end
  assign INT_N_O = 1'b0; // RULE15

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  flag_set_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE9
    (done_pulse && irq_en_reg) |=> flag_reg && !INT_OE_N)
    else $error("Flag not set at end of count");

  flag_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE14
    (flag_reg && !flag_clear) |=> flag_reg)
    else $error("Flag dropped without a clearing write");

  pin_follow_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE10
    INT_OE_N == !flag_reg)
    else $error("Interrupt pin does not follow flag");

  no_flag_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE9
    (!irq_en_reg && !flag_reg) |=> !flag_reg)
    else $error("Flag set with interrupt disabled");

  sel_lock_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE11
    (wr_ctrl && ctrl_reg.run) |=> $stable(ctrl_reg.sel) && $stable(ctrl_reg.arl))
    else $error("Select or reload changed while running");

  cnt_lock_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE12
    (ctrl_reg.run || ctrl_reg.arl) |=> $stable(load_reg))
    else $error("Count value changed while locked");

  count_dec_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE17
    (state_reg == cdt_pkg::CDT_ST_RUN && src_tick && !wr_ctrl) |=> cnt_reg == $past(cnt_reg) - 16'h0001)
    else $error("Counter did not decrement on tick");

  one_shot_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE16
    (done_pulse && !ctrl_reg.arl && !wr_ctrl) |=> state_reg == cdt_pkg::CDT_ST_IDLE && cnt_reg == 16'h0000)
    else $error("Timer did not stop at zero");

  reload_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE7
    (state_reg == cdt_pkg::CDT_ST_RELOAD && src_tick && !wr_ctrl) |=>
      state_reg == cdt_pkg::CDT_ST_RUN && cnt_reg == load_reg)
    else $error("Reload tick did not restore the count");

  stop_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE1
    !ctrl_reg.run |-> state_reg == cdt_pkg::CDT_ST_IDLE)
    else $error("Counting while run bit clear");

  zero_load_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE4
    (run_start && load_reg == 16'h0000) |=> state_reg == cdt_pkg::CDT_ST_IDLE)
    else $error("Zero count started the timer");

  start_load_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE3
    (run_start && load_reg != 16'h0000) |=>
      state_reg == cdt_pkg::CDT_ST_RUN && cnt_reg == $past(load_reg))
    else $error("Start did not load the count value");

  tick_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE17
    (state_reg == cdt_pkg::CDT_ST_RUN && !src_tick && !wr_ctrl) |=> $stable(cnt_reg))
    else $error("Counter moved without a source tick");

  reload_wait_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE7
    (state_reg == cdt_pkg::CDT_ST_RELOAD && !src_tick && !wr_ctrl) |=>
      state_reg == cdt_pkg::CDT_ST_RELOAD)
    else $error("Reload finished before its source tick");

  done_reload_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE6
    (done_pulse && ctrl_reg.arl && !wr_ctrl) |=>
      state_reg == cdt_pkg::CDT_ST_RELOAD && cnt_reg == 16'h0000)
    else $error("Auto-reload did not enter the reload tick");

  flag_clr_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE10
    (flag_clear && !(done_pulse && irq_en_reg)) |=> !flag_reg && INT_OE_N)
    else $error("Clearing write did not release the interrupt");

  idle_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE16
    (state_reg == cdt_pkg::CDT_ST_IDLE && !run_start) |=> state_reg == cdt_pkg::CDT_ST_IDLE)
    else $error("Timer left idle without a start");

endmodule : cdt_timer

// ### src/cdt_pkg.sv
// Package of constants, types and register map for the countdown timer block
// Function
// RULE1: Countdown runs only while the run bit (control bit 1) is set.
// RULE2: Control bits 6:5 select source clock: 32, 8, 1 or 0.5 Hz.
// RULE3: Sixteen-bit count value, low byte at index 18h, high at 19h.
// RULE4: Nonzero counts are valid; a loaded count of zero stops the timer.
// RULE5: A countdown period ends when the counter reaches zero.
// RULE6: With auto-reload (control bit 2) the count reloads and restarts each period.
// RULE7: Auto-reload spends one extra source tick reloading before counting resumes.
// RULE8: First period lasts n ticks, later reloaded periods n+1 ticks.
// RULE9: With interrupt enable bit 1 set, end of count sets flag bit 1.
// RULE10: Interrupt output follows the flag; host writes zero to release it.
// RULE11: Source select and auto-reload are writable only while the timer is stopped.
// RULE12: Count registers are writable only while run and auto-reload are clear.
// RULE13: After reset timer and auto-reload are off, 32 Hz source selected.
// RULE14: Flag and interrupt output stay asserted until software writes flag zero.
// RULE15: Interrupt output is active low.
// RULE16: Without auto-reload the timer stops at zero after one period.
// RULE17: Counter decrements once per selected source tick while running and nonzero.
package cdt_pkg;
  // ----------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------
  localparam logic [7:0] CDT_IDX_CTRL = 8'h00;
  localparam logic [7:0] CDT_IDX_IEN = 8'h01;
  localparam logic [7:0] CDT_IDX_IFLG = 8'h02;
  localparam logic [7:0] CDT_IDX_CNTLO = 8'h18;
  localparam logic [7:0] CDT_IDX_CNTHI = 8'h19;
  localparam int CDT_ADDR_W = 10;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CDT_CTRL_RUN = 1;
  localparam int CDT_CTRL_ARL = 2;
  localparam int CDT_CTRL_SEL_LO = 5;
  localparam int CDT_CTRL_SEL_HI = 6;
  localparam int CDT_IRQ_BIT = 1;
  localparam logic [1:0] CDT_SEL_RESET = 2'h0;
  localparam logic [15:0] CDT_CNT_RESET = 16'h0000;

  // ----------------------------------------
  // Timing: base tick rate from the main clock
  // ----------------------------------------
  localparam int CDT_MCLK_HZ = 40000000;
  localparam int CDT_BASE_HZ = 32;
  localparam int CDT_BASE_CYCLES = CDT_MCLK_HZ / CDT_BASE_HZ;
  localparam logic [5:0] CDT_DIV_8HZ = 6'h03;
  localparam logic [5:0] CDT_DIV_1HZ = 6'h1f;
  localparam logic [5:0] CDT_DIV_HALF = 6'h3f;

  // Source clock select codes
  typedef enum logic [1:0] {
    CDT_SRC_32HZ = 2'h0,
    CDT_SRC_8HZ = 2'h1,
    CDT_SRC_1HZ = 2'h2,
    CDT_SRC_HALF = 2'h3
  } cdt_src_e;

  // Countdown states, one-hot
  typedef enum logic [2:0] {
    CDT_ST_IDLE = 3'h1,
    CDT_ST_RUN = 3'h2,
    CDT_ST_RELOAD = 3'h4
  } cdt_state_e;

  // Timer control fields
  typedef struct packed {
    cdt_src_e sel;
    logic arl;
    logic run;
  } cdt_ctrl_s;
endpackage : cdt_pkg

// ### tb/cdt_host.sv
// APB host model that programs the timer and resolves the interrupt pin
module cdt_host (
  input wire logic clk,
  input wire logic pready,
  input wire logic int_n_o,
  input wire logic int_oe_n,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [9:0] paddr,
  output logic [31:0] pwdata,
  output logic int_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Idle bus and pin level
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
  end
  // Pull-up holds the released open-drain line high
  assign int_pin = int_oe_n ? 1'b1 : int_n_o;
  // One APB transfer, held until pready is seen high
  task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Release the interrupt by writing zero to the flag
  task clr();
    xfer(1'b1, cdt_pkg::CDT_IDX_IFLG, 8'h00);
    repeat (2) @(posedge clk);
  endtask : clr
  // Stop the timer before touching select, reload or count
  task stop();
    xfer(1'b1, cdt_pkg::CDT_IDX_CTRL, 8'h00);
  endtask : stop
endmodule : cdt_host

// ### tb/testbench.sv
// Self-checking bench for the countdown timer
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BC = 8;
  localparam logic [7:0] CT = cdt_pkg::CDT_IDX_CTRL;
  localparam logic [7:0] FL = cdt_pkg::CDT_IDX_IFLG;
  localparam logic [7:0] LO = cdt_pkg::CDT_IDX_CNTLO;
  localparam logic [7:0] HI = cdt_pkg::CDT_IDX_CNTHI;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, int_n_o, int_oe_n, int_pin;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] expq[$];
  logic [7:0] lo, hi;
  int err_total = 0, checks_done = 0, cyc = 0, seed = 38404, t1, t2;
  int per[4] = '{1, 4, 32, 64};
  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  always #12.5 MCLK = ~MCLK;
  cdt_timer #(.BASE_CYCLES(BC)) dut (.MCLK(MCLK), .RST_N(RST_N), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .INT_N_O(int_n_o), .INT_OE_N(int_oe_n));
  cdt_host host (.clk(MCLK), .pready(pready), .int_n_o(int_n_o), .int_oe_n(int_oe_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .int_pin(int_pin));
  // ----------------------------------------
  // Checking, scoreboard and run control
  // ----------------------------------------
  task chk(input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  task stop_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task wr(input logic [7:0] i, input logic [7:0] d);
    host.xfer(1'b1, i, d);
  endtask : wr
  task rd(input logic [7:0] i, input logic [32:0] e);
    expq.push_back(e);
    host.xfer(1'b0, i, 8'h00);
  endtask : rd
  // Wait for the interrupt pin to go low, bounded
  task wirq(output int t);
    int n;
    n = 0;
    while (int_pin !== 1'b0 && n < 3000) begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 3000) chk(33'h0, 33'h1);
    t = cyc;
  endtask : wirq
  // Read results compared against the oldest note
  always @(posedge MCLK) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) chk(33'h0, 33'h1);
      else chk(expq.pop_front(), {pslverr, prdata});
    end
  end
  // Cycle count and hang guard
  always @(posedge MCLK) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    rd(CT, 33'h0);
    rd(HI, 33'h0);
    rd(FL, 33'h0);
    rd(8'h03, {1'b1, 32'h0});
    chk(33'h1, 33'(int_pin));
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    wr(LO, lo);
    wr(HI, hi);
    rd(LO, 33'(lo));
    rd(HI, 33'(hi));
    // Single period of three ticks, flag held until cleared
    wr(LO, 8'h03);
    wr(HI, 8'h00);
    wr(cdt_pkg::CDT_IDX_IEN, 8'h02);
    rd(cdt_pkg::CDT_IDX_IEN, 33'h2);
    wr(CT, 8'h02);
    t1 = cyc;
    wirq(t2);
    chk(33'h1, 33'((t2 - t1) >= 2 * BC + 1 && (t2 - t1) <= 3 * BC + 2));
    repeat (40) @(posedge MCLK);
    chk(33'h0, 33'(int_pin));
    rd(FL, 33'h2);
    wr(CT, 8'h66);
    rd(CT, 33'h2);
    wr(LO, 8'h55);
    rd(LO, 33'h3);
    host.clr();
    repeat (300) @(posedge MCLK);
    chk(33'h1, 33'(int_pin));
    // Stop in mid-count, then start with a zero count
    host.stop();
    wr(LO, 8'h05);
    wr(CT, 8'h02);
    repeat (20) @(posedge MCLK);
    wr(CT, 8'h00);
    repeat (100) @(posedge MCLK);
    chk(33'h1, 33'(int_pin));
    wr(LO, 8'h00);
    wr(CT, 8'h02);
    repeat (100) @(posedge MCLK);
    chk(33'h1, 33'(int_pin));
    host.stop();
    // Every source rate with auto-reload, count of two
    for (int s = 0; s < 4; s++) begin
      wr(LO, 8'h02);
      wr(CT, {1'b0, 2'(s), 5'b00100});
      wr(LO, 8'h07);
      rd(LO, 33'h2);
      wr(CT, {1'b0, 2'(s), 5'b00110});
      rd(CT, 33'({1'b0, 2'(s), 5'b00110}));
      wirq(t1);
      host.clr();
      wirq(t2);
      chk(33'(3 * BC * per[s]), 33'(t2 - t1));
      host.stop();
      host.clr();
    end
    // Reset in mid-count brings back the stopped, 32 Hz state
    wr(CT, 8'h66);
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    rd(CT, 33'h0);
    rd(FL, 33'h0);
    chk(33'h1, 33'(int_pin));
    stop_test();
  end
endmodule : testbench
